// >>> hdl/ubi_irq_source.sv
// interrupt source register for bulk in endpoint 1 with clear, mask and interrupt line
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module ubi_irq_source
  import ubi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        in_nak_evt,
  input  wire logic        fifo_toggle_evt,
  input  wire logic        ep1_buf_write,
  input  wire logic        intf_ep1_enable_pin,
  output logic             usb_function_irq_line
);
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] chg;
    logic [7:0] mask;
    logic [7:0] map;
    logic [7:0] rdata;
  } ubi_irq_source_s;
  ubi_irq_source_s st_r, st_nxt;

  logic intf_en;
  logic intf_rise;
  logic ep_valid;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  // interface setting arrives from a pin
  ubi_sync #(.W(1)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       (intf_ep1_enable_pin),
    .q       (intf_en)
  );

  // enable edge detect, kept for observation of re-enable
  ubi_pulse u_pulse (
    .ref_clk (ref_clk),
    .reset   (reset),
    .lvl     (intf_en),
    .rise    (intf_rise)
  );

  assign ep_valid = intf_en & st_r.map[UBI_MAP_EP1];

  // next state of all registers
  always_comb begin
    st_nxt = st_r;
    set_v  = 8'h00;
    clr_v  = 8'h00;
    set_v[UBI_NAK_BIT] = in_nak_evt;
    set_v[UBI_TGL_BIT] = fifo_toggle_evt;
    clr_v[UBI_TGL_BIT] = ep1_buf_write;
    if (reg_wr && reg_addr == UBI_CLR_ADDR) begin
      clr_v = clr_v | (~reg_wdata & UBI_USED_BITS);
    end
    if (reg_wr && reg_addr == UBI_MASK_ADDR) begin
      st_nxt.mask = reg_wdata & UBI_USED_BITS;
    end
    if (reg_wr && reg_addr == UBI_MAP_ADDR) begin
      st_nxt.map = reg_wdata;
    end
    // a write to the source address has no effect
    if (!ep_valid) begin
      st_nxt.src = 8'h00;
    end else begin
      st_nxt.src = ((st_r.src & ~clr_v) | set_v) & UBI_USED_BITS; // set wins
    end
    // sticky change bits: any bit that rose raises the line unless masked
    st_nxt.chg = st_r.chg & st_nxt.src | (st_nxt.src & ~st_r.src);
    if (reg_wr && reg_addr == UBI_CLR_ADDR) begin
      st_nxt.chg = (st_r.chg & st_nxt.src & reg_wdata) | (st_nxt.src & ~st_r.src);
    end
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        UBI_SRC_ADDR:  st_nxt.rdata = st_r.src;
        UBI_MASK_ADDR: st_nxt.rdata = st_r.mask;
        UBI_MAP_ADDR:  st_nxt.rdata = st_r.map;
        default:       st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // register all state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r.src   <= UBI_SRC_RESET;
      st_r.chg   <= 8'h00;
      st_r.mask  <= UBI_MASK_RESET;
      st_r.map   <= UBI_MAP_RESET;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign usb_function_irq_line = |(st_r.chg & st_r.src & ~st_r.mask);

  // decoded register strobes shared by the checks below
  logic clr_wr;
  logic mask_wr;
  logic map_wr;
  logic src_rd;
  assign clr_wr  = reg_wr && (reg_addr == UBI_CLR_ADDR);
  assign mask_wr = reg_wr && (reg_addr == UBI_MASK_ADDR);
  assign map_wr  = reg_wr && (reg_addr == UBI_MAP_ADDR);
  assign src_rd  = reg_rd && (reg_addr == UBI_SRC_ADDR);

  // nak event on a valid endpoint sets bit 5
  property p_nak_set;
    @(posedge ref_clk) disable iff (reset)
      in_nak_evt && ep_valid |=> st_r.src[UBI_NAK_BIT];
  endproperty
  a_nak_set: assert property (p_nak_set) else $error("nak flag not set");

  // fifo toggle on a valid endpoint sets bit 4
  property p_tgl_set;
    @(posedge ref_clk) disable iff (reset)
      fifo_toggle_evt && ep_valid |=> st_r.src[UBI_TGL_BIT];
  endproperty
  a_tgl_set: assert property (p_tgl_set) else $error("toggle flag not set");

  // a buffer write with no toggle beside it drops bit 4
  property p_tgl_clr;
    @(posedge ref_clk) disable iff (reset)
      ep1_buf_write && !fifo_toggle_evt |=> !st_r.src[UBI_TGL_BIT];
  endproperty
  a_tgl_clr: assert property (p_tgl_clr) else $error("toggle flag not cleared by write");

  // a zero written to the clear register drops bit 5
  property p_clear_zero;
    @(posedge ref_clk) disable iff (reset)
      reg_wr && reg_addr == UBI_CLR_ADDR && !reg_wdata[UBI_NAK_BIT] && !in_nak_evt
        |=> !st_r.src[UBI_NAK_BIT];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear write ignored");

  // disabled endpoint keeps every source bit at zero
  property p_invalid;
    @(posedge ref_clk) disable iff (reset)
      !ep_valid |=> st_r.src == 8'h00;
  endproperty
  a_invalid: assert property (p_invalid) else $error("bits live on disabled endpoint");

  // writes to the source address leave it alone
  property p_ro;
    @(posedge ref_clk) disable iff (reset)
      reg_wr && reg_addr == UBI_SRC_ADDR && !in_nak_evt && !fifo_toggle_evt && !ep1_buf_write && ep_valid
        |=> st_r.src == $past(st_r.src);
  endproperty
  a_ro: assert property (p_ro) else $error("source register changed by write");

  // a fresh unmasked nak raises the line, mask untouched meanwhile
  sequence s_rise;
    ep_valid && !st_r.src[UBI_NAK_BIT] && in_nak_evt && !st_r.mask[UBI_NAK_BIT]
      && !mask_wr;
  endsequence
  property p_irq;
    @(posedge ref_clk) disable iff (reset)
      s_rise |=> usb_function_irq_line;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt on change");

  // source read data stand one cycle after the strobe
  property p_read;
    @(posedge ref_clk) disable iff (reset)
      reg_rd && reg_addr == UBI_SRC_ADDR |=> reg_rdata == $past(st_r.src);
  endproperty
  a_read: assert property (p_read) else $error("source read data wrong");

  // the source bits are empty whenever the interface setting comes back
  property p_reenable;
    @(posedge ref_clk) disable iff (reset)
      intf_rise |-> st_r.src == 8'h00;
  endproperty
  a_reenable: assert property (p_reenable) else $error("source bits alive at re-enable");

  // bits other than 5 and 4 always stay zero
  property p_unused;
    @(posedge ref_clk) disable iff (reset)
      (st_r.src & ~UBI_USED_BITS) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused source bit set");

  // bit 5 is sticky until a zero is written to its clear bit
  property p_nak_hold;
    @(posedge ref_clk) disable iff (reset)
      ep_valid && st_r.src[UBI_NAK_BIT] && !(clr_wr && !reg_wdata[UBI_NAK_BIT]) |=> st_r.src[UBI_NAK_BIT];
  endproperty
  a_nak_hold: assert property (p_nak_hold) else $error("nak flag lost");

  // bit 4 is sticky until cleared or written over
  property p_tgl_hold;
    @(posedge ref_clk) disable iff (reset)
      ep_valid && st_r.src[UBI_TGL_BIT] && !ep1_buf_write && !(clr_wr && !reg_wdata[UBI_TGL_BIT])
        |=> st_r.src[UBI_TGL_BIT];
  endproperty
  a_tgl_hold: assert property (p_tgl_hold) else $error("toggle flag lost");

  // bit 5 only ever rises on a nak event
  property p_nak_only_evt;
    @(posedge ref_clk) disable iff (reset)
      !in_nak_evt && !st_r.src[UBI_NAK_BIT] |=> !st_r.src[UBI_NAK_BIT];
  endproperty
  a_nak_only_evt: assert property (p_nak_only_evt) else $error("nak flag set without event");

  // bit 4 only ever rises on a fifo toggle
  property p_tgl_only_evt;
    @(posedge ref_clk) disable iff (reset)
      !fifo_toggle_evt && !st_r.src[UBI_TGL_BIT] |=> !st_r.src[UBI_TGL_BIT];
  endproperty
  a_tgl_only_evt: assert property (p_tgl_only_evt) else $error("toggle flag set without event");

  // a zero written to the clear register drops bit 4
  property p_clear_tgl;
    @(posedge ref_clk) disable iff (reset)
      clr_wr && !reg_wdata[UBI_TGL_BIT] && !fifo_toggle_evt |=> !st_r.src[UBI_TGL_BIT];
  endproperty
  a_clear_tgl: assert property (p_clear_tgl) else $error("toggle clear write ignored");

  // nothing unmasked set means the line is low
  property p_irq_masked;
    @(posedge ref_clk) disable iff (reset)
      (st_r.src & ~st_r.mask) == 8'h00 |-> !usb_function_irq_line;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with nothing unmasked");

  // a fresh unmasked toggle raises the line as well
  sequence s_tgl_rise;
    ep_valid && !st_r.src[UBI_TGL_BIT] && fifo_toggle_evt && !st_r.mask[UBI_TGL_BIT] && !mask_wr;
  endsequence
  property p_irq_tgl;
    @(posedge ref_clk) disable iff (reset)
      s_tgl_rise |=> usb_function_irq_line;
  endproperty
  a_irq_tgl: assert property (p_irq_tgl) else $error("no interrupt on toggle");

  // the line stays up on an enabled endpoint until software touches clear or mask or a buffer write comes
  property p_irq_hold;
    @(posedge ref_clk) disable iff (reset)
      usb_function_irq_line && ep_valid && !clr_wr && !mask_wr && !ep1_buf_write |=> usb_function_irq_line;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped on its own");

  // firmware reading right after a nak event sees bit 5
  sequence s_nak_seen;
    in_nak_evt && ep_valid;
  endsequence
  sequence s_src_read;
    src_rd;
  endsequence
  property p_read_nak;
    @(posedge ref_clk) disable iff (reset)
      s_nak_seen ##1 s_src_read |=> reg_rdata[UBI_NAK_BIT];
  endproperty
  a_read_nak: assert property (p_read_nak) else $error("nak cause not readable");

  // firmware reading right after a toggle sees bit 4
  sequence s_tgl_seen;
    fifo_toggle_evt && ep_valid;
  endsequence
  property p_read_tgl;
    @(posedge ref_clk) disable iff (reset)
      s_tgl_seen ##1 s_src_read |=> reg_rdata[UBI_TGL_BIT];
  endproperty
  a_read_tgl: assert property (p_read_tgl) else $error("toggle cause not readable");

  // read data are zero outside the cycle after a read
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

  // a mask write lands on the used bits only
  property p_mask_wr;
    @(posedge ref_clk) disable iff (reset)
      mask_wr |=> st_r.mask == ($past(reg_wdata) & UBI_USED_BITS);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  // a map write lands whole
  property p_map_wr;
    @(posedge ref_clk) disable iff (reset)
      map_wr |=> st_r.map == $past(reg_wdata);
  endproperty
  a_map_wr: assert property (p_map_wr) else $error("map write lost");

  // endpoint left out of the map keeps the source empty
  property p_map_off;
    @(posedge ref_clk) disable iff (reset)
      !st_r.map[UBI_MAP_EP1] |=> st_r.src == 8'h00;
  endproperty
  a_map_off: assert property (p_map_off) else $error("bits live on unmapped endpoint");
endmodule // ubi_irq_source

// >>> shared/ubi_pkg.sv
// constants for the bulk in endpoint 1 interrupt source register
package ubi_pkg;
  localparam logic [15:0] UBI_SRC_ADDR   = 16'hff29; // source register, read only
  localparam logic [15:0] UBI_CLR_ADDR   = 16'hff30; // companion clear register
  localparam logic [15:0] UBI_MASK_ADDR  = 16'hff31; // interrupt mask
  localparam logic [15:0] UBI_MAP_ADDR   = 16'hff32; // endpoint map setting
  localparam int          UBI_NAK_BIT    = 5;
  localparam int          UBI_TGL_BIT    = 4;
  localparam logic [7:0]  UBI_SRC_RESET  = 8'h00;
  localparam logic [7:0]  UBI_MASK_RESET = 8'h00;
  localparam logic [7:0]  UBI_USED_BITS  = 8'h30;
  localparam logic [7:0]  UBI_MAP_RESET  = 8'h00;
  localparam int          UBI_MAP_EP1    = 0;
endpackage

// >>> hdl/ubi_sync.sv
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ns
module ubi_sync
  import ubi_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ubi_sync_s;
  ubi_sync_s st_r, st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // register stages
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // ubi_sync

// >>> hdl/ubi_pulse.sv
// rising edge detector turning a level into a one cycle event
`timescale 1ns/1ns
module ubi_pulse
  import ubi_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic lvl,
  output logic      rise
);
  typedef struct packed {
    logic prev;
  } ubi_pulse_s;
  ubi_pulse_s st_r, st_nxt;

  // remember previous level
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = lvl;
  end

  // register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = lvl & ~st_r.prev;
endmodule // ubi_pulse

// >>> tb/ubi_host_model.sv
// behavioural usb host issuing in tokens to endpoint 1
`timescale 1ns/1ns
module ubi_host_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       tok_go,
  input  wire logic       tok_kind,
  input  wire logic [3:0] tok_dly,
  output logic            in_nak_evt,
  output logic            fifo_toggle_evt
);
  logic [4:0] cnt_r;
  logic       kind_r;
  // answers each token after a chosen delay, prompt or slow; busy tokens are dropped
  always_ff @(posedge ref_clk) begin
    in_nak_evt <= 1'b0;
    fifo_toggle_evt <= 1'b0;
    if (reset) begin
      cnt_r <= 5'h00;
      kind_r <= 1'b0;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      if (cnt_r == 5'h01) begin
        in_nak_evt <= !kind_r;
        fifo_toggle_evt <= kind_r;
      end
    end else if (tok_go) begin
      cnt_r <= {1'b0, tok_dly} + 5'h01;
      kind_r <= tok_kind;
    end
  end
endmodule // ubi_host_model

// >>> tb/usb_bulk_in1_int_status_tb_top.sv
// random testbench with cycle model for the endpoint 1 interrupt source register
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module usb_bulk_in1_int_status_tb_top
  import ubi_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b1, irq;
  logic ep1_buf_write = 1'b0, tok_go = 1'b0, tok_kind = 1'b0, in_nak_evt, fifo_toggle_evt;
  logic [15:0] reg_addr = 16'h0000, rnd = 16'hb30f;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, m_src, m_pend, m_mask, m_map, m_rd, o;
  logic [3:0]  tok_dly = 4'h0;
  logic [2:0]  op;
  logic [1:0]  ps;
  logic        ok;
  int          n_mismatch = 0, check_count = 0;
  ubi_irq_source dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_nak_evt(in_nak_evt),
    .fifo_toggle_evt(fifo_toggle_evt), .ep1_buf_write(ep1_buf_write), .intf_ep1_enable_pin(pin),
    .usb_function_irq_line(irq));
  ubi_host_model host_u (.ref_clk(ref_clk), .reset(reset), .tok_go(tok_go), .tok_kind(tok_kind),
    .tok_dly(tok_dly), .in_nak_evt(in_nak_evt), .fifo_toggle_evt(fifo_toggle_evt));
  // clock generator
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // cycle model of the register file, updated on every rising edge
  always @(posedge ref_clk) begin
    o = m_src;
    ok = m_map[UBI_MAP_EP1] & ps[1];
    ps = reset ? 2'b00 : {ps[0], pin};
    m_rd = 8'h00;
    if (!reset && reg_rd && reg_addr == UBI_SRC_ADDR) m_rd = o;
    if (!reset && reg_rd && reg_addr == UBI_MASK_ADDR) m_rd = m_mask;
    if (!reset && reg_rd && reg_addr == UBI_MAP_ADDR) m_rd = m_map;
    if (reset) begin
      m_src = UBI_SRC_RESET;
      m_pend = 8'h00;
      m_mask = UBI_MASK_RESET;
      m_map = UBI_MAP_RESET;
    end else begin
      if (reg_wr && reg_addr == UBI_CLR_ADDR) begin
        m_src = m_src & reg_wdata;
        m_pend = m_pend & reg_wdata; // a one written leaves the change pending
      end
      if (reg_wr && reg_addr == UBI_MASK_ADDR) m_mask = reg_wdata & UBI_USED_BITS;
      if (reg_wr && reg_addr == UBI_MAP_ADDR) m_map = reg_wdata;
      if (ep1_buf_write) m_src[UBI_TGL_BIT] = 1'b0;
      if (!ok) begin
        m_src = 8'h00;
      end else begin
        if (in_nak_evt) begin
          m_src[UBI_NAK_BIT] = 1'b1;
          if (!o[UBI_NAK_BIT]) m_pend[UBI_NAK_BIT] = 1'b1;
        end
        if (fifo_toggle_evt) begin
          m_src[UBI_TGL_BIT] = 1'b1;
          if (!o[UBI_TGL_BIT]) m_pend[UBI_TGL_BIT] = 1'b1;
        end
      end
    end
  end
  // compare outputs mid-cycle where they are settled
  always @(negedge ref_clk) begin
    `CHK(reg_rdata, m_rd)
    `CHK(irq, |(m_src & m_pend & ~m_mask))
  end
  // watchdog well beyond the expected run
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
  // reset, then one random register or host operation per cycle
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6000; i++) begin
      @(posedge ref_clk);
      reset <= (i >= 3000) && (i < 3003); // second reset in mid-run
      rnd = lfsr_next(rnd);
      op = rnd[2:0];
      reg_rd <= (op == 3'h0) || (op == 3'h3 && irq);
      reg_wr <= (op >= 3'h4);
      reg_addr <= op == 3'h0 ? (rnd[3] ? UBI_SRC_ADDR : rnd[9] ? UBI_MASK_ADDR :
                  rnd[10] ? UBI_MAP_ADDR : 16'hff40) : op == 3'h4 ? UBI_CLR_ADDR :
                  op == 3'h5 ? UBI_MASK_ADDR : op == 3'h6 ? UBI_MAP_ADDR : UBI_SRC_ADDR;
      reg_wdata <= op == 3'h6 ? {7'h00, rnd[8] | rnd[9]} : rnd[15:8];
      tok_go <= (op == 3'h1);
      tok_kind <= rnd[4];
      tok_dly <= rnd[7:4];
      ep1_buf_write <= (op == 3'h2) && rnd[5];
      if (op == 3'h3 && rnd[15:12] == 4'h0) pin <= ~pin;
    end
    stop_test();
  end
endmodule // usb_bulk_in1_int_status_tb_top
